// file: verilog/fap_pkg.sv
/*
  Package for the flash access and protection block: register offsets,
  field positions, reset values, key bytes and timing constants.
  Assumes an 8-bit I/O register path from the processor core.
*/
package fap_pkg;
  // I/O register offsets
  localparam logic [7:0] FAP_KEY_ADDR = 8'hf5;
  localparam logic [7:0] FAP_CTRL_ADDR = 8'hf8;
  localparam logic [7:0] FAP_DIV_ADDR = 8'hf9;
  localparam logic [7:0] FAP_GUARD_ADDR = 8'hfa;
  // Access control fields
  localparam int FAP_WAIT_MSB = 7;
  localparam int FAP_WAIT_LSB = 5;
  localparam int FAP_EN_BIT = 3;
  // Reset values
  localparam logic [2:0] FAP_WAIT_RST = 3'h4;
  localparam logic FAP_EN_RST = 1'b1;
  localparam logic [7:0] FAP_DIV_RST = 8'h01;
  localparam logic [7:0] FAP_GUARD_RST = 8'hff;
  localparam logic [7:0] FAP_GUARD_ALL = 8'hff;
  // Unlock key bytes
  localparam logic [7:0] FAP_KEY_FIRST = 8'hb6;
  localparam logic [7:0] FAP_KEY_SECOND = 8'h49;
  // Flash geometry: 16 KB blocks over a 17-bit offset
  localparam int FAP_OFS_W = 17;
  localparam int FAP_BLK_LSB = 14;
  // Timing
  localparam int FAP_CLK_MHZ = 100;
  localparam real FAP_ACCESS_NS = 60.0;
  localparam int FAP_ACCESS_CYC = 6;

  // Unlock sequencer states
  typedef enum logic [1:0] {
    FAP_LOCKED = 2'b00,
    FAP_HALF = 2'b01,
    FAP_OPEN = 2'b10
  } fap_lock_e;

  // One processor bus cycle
  typedef struct packed {
    logic io_wr;
    logic io_rd;
    logic mem_acc;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fap_bus_s;

  // One flash write or erase request
  typedef struct packed {
    logic wr;
    logic page_erase;
    logic mass_erase;
    logic [FAP_OFS_W-1:0] ofs;
  } fap_op_s;
endpackage : fap_pkg

// file: verilog/fap_clk_div.sv
/*
  Programming clock divider: one tick every div_in system clocks.
  Assumes div_in is never zero; zero is treated as one.
*/
module fap_clk_div
  import fap_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Divider value
  input wire logic [7:0] div_in,
  // Tick output
  output logic tick_out
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // Count up to the divider value, then tick and restart
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 8'h01;
    if (cnt_r + 8'h01 >= div_in) begin
      cnt_nxt = 8'h00;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;

  // Tick spacing equals the divider value, watched at divider three
  a_tick_spacing: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    tick_r && div_in == 8'h03 && $stable(div_in)
    |=> !tick_r [*2] ##1 (tick_r || div_in != 8'h03))
    else $error("tick spacing differs from divider");
endmodule : fap_clk_div

// file: verilog/fap_top.sv
/*
  Flash access and protection: wait states, memory window enable,
  programming clock divider and block write guard behind a key.
  Assumes one processor bus cycle per clock on the bus input and
  that the core holds a flash read while wait_req_out is high.
*/
// How it works
// - I/O register path works with window disabled
// - Wait field bits 7:5 gives wait count
// - Four wait states after reset
// - Bit 3 enables window, resets to one
// - Programming tick is system clock divided
// - Divider is 8 bits, resets to one
// - Divider writes only while unlocked
// - Programming works from 154 kHz to 50 MHz
// - Guard bit one blocks write and erase
// - Bit n guards offsets n times 4000h
// - All guard bits set on reset
// - Mass erase refused if any guard set
// - Locked guard write forces FFh
// - Unlock needs B6h then 49h back to back
// - Divider or guard write relocks both
// - Guarded write refused, violation flag set
module fap_top
  import fap_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Processor bus cycle
  input wire fap_bus_s bus_in,
  output logic [7:0] rdata_out,
  // Flash memory read start and core stall
  input wire logic flash_rd_in,
  output logic wait_req_out,
  output logic window_en_out,
  // Write and erase requests toward the array
  input wire fap_op_s op_in,
  output logic op_go_out,
  output logic op_refused_out,
  output logic write_violation_flag_out,
  input wire logic violation_clr_in,
  // Programming clock tick
  output logic prog_tick_out
);
  logic [2:0] wait_r;
  logic [2:0] wait_nxt;
  logic en_r;
  logic en_nxt;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [7:0] block_write_guard_r;
  logic [7:0] guard_nxt;
  fap_lock_e lock_r;
  fap_lock_e lock_nxt;
  logic [2:0] wcnt_r;
  logic [2:0] wcnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic viol_r;
  logic viol_nxt;
  logic go_r;
  logic go_nxt;
  logic ref_r;
  logic ref_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic unlocked;
  logic [7:0] blk_hit;
  logic [FAP_OFS_W-FAP_BLK_LSB-1:0] blk_idx;
  logic op_any;
  logic op_bad;
  logic hold_r;
  logic hold_nxt;
  logic rd_take;

  assign unlocked = (lock_r == FAP_OPEN);
  assign blk_idx = op_in.ofs[FAP_OFS_W-1:FAP_BLK_LSB];

  // One decode term per guard block
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_blk
      assign blk_hit[gi] = block_write_guard_r[gi] && (blk_idx == 3'(gi));
    end
  endgenerate

  assign op_any = op_in.wr | op_in.page_erase | op_in.mass_erase;
  assign op_bad = ((op_in.wr | op_in.page_erase) && (|blk_hit))
    || (op_in.mass_erase && (|block_write_guard_r));

  // Key sequencer: only consecutive I/O writes count
  always_comb begin
    lock_nxt = lock_r;
    if (bus_in.io_wr) begin
      if (bus_in.addr == FAP_DIV_ADDR || bus_in.addr == FAP_GUARD_ADDR) begin
        lock_nxt = FAP_LOCKED;
      end else if (bus_in.addr == FAP_KEY_ADDR) begin
        if (bus_in.wdata == FAP_KEY_FIRST) begin
          lock_nxt = FAP_HALF;
        end else if (lock_r == FAP_HALF && bus_in.wdata == FAP_KEY_SECOND) begin
          lock_nxt = FAP_OPEN;
        end else begin
          lock_nxt = FAP_LOCKED;
        end
      end else if (lock_r == FAP_HALF) begin
        lock_nxt = FAP_LOCKED;
      end
    end else if ((bus_in.io_rd || bus_in.mem_acc) && lock_r == FAP_HALF) begin
      lock_nxt = FAP_LOCKED;
    end
  end

  // Register writes and read mux, independent of the window enable
  always_comb begin
    wait_nxt = wait_r;
    en_nxt = en_r;
    div_nxt = div_r;
    guard_nxt = block_write_guard_r;
    rdata_nxt = rdata_r;
    if (bus_in.io_wr) begin
      unique case (bus_in.addr)
        FAP_CTRL_ADDR: begin
          wait_nxt = bus_in.wdata[FAP_WAIT_MSB:FAP_WAIT_LSB];
          en_nxt = bus_in.wdata[FAP_EN_BIT];
        end
        FAP_DIV_ADDR: begin
          if (unlocked && bus_in.wdata != 8'h00) begin
            div_nxt = bus_in.wdata;
          end
        end
        FAP_GUARD_ADDR: begin
          guard_nxt = unlocked ? bus_in.wdata : FAP_GUARD_ALL;
        end
        default: begin
        end
      endcase
    end
    if (bus_in.io_rd) begin
      unique case (bus_in.addr)
        FAP_CTRL_ADDR: rdata_nxt = {wait_r, 1'b0, en_r, 3'h0};
        FAP_DIV_ADDR: rdata_nxt = div_r;
        FAP_GUARD_ADDR: rdata_nxt = block_write_guard_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Start of a flash read that has not been stalled yet
  assign rd_take = flash_rd_in && en_r && wait_r != 3'h0 && !busy_r && !hold_r;

  // Wait state counter; hold keeps a served read from stalling again
  always_comb begin
    wcnt_nxt = wcnt_r;
    busy_nxt = busy_r;
    hold_nxt = hold_r;
    if (!flash_rd_in) begin
      hold_nxt = 1'b0;
    end
    if (busy_r) begin
      if (wcnt_r == 3'h1) begin
        busy_nxt = 1'b0;
        hold_nxt = flash_rd_in;
      end
      wcnt_nxt = wcnt_r - 3'h1;
    end else if (rd_take) begin
      busy_nxt = 1'b1;
      wcnt_nxt = wait_r;
    end
  end

  // Guard check on write and erase requests; set wins over clear
  always_comb begin
    go_nxt = op_any && !op_bad;
    ref_nxt = op_any && op_bad;
    viol_nxt = viol_r;
    if (violation_clr_in) begin
      viol_nxt = 1'b0;
    end
    if (op_in.wr && op_bad) begin
      viol_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_r <= FAP_WAIT_RST;
      en_r <= FAP_EN_RST;
      div_r <= FAP_DIV_RST;
      block_write_guard_r <= FAP_GUARD_RST;
      lock_r <= FAP_LOCKED;
      wcnt_r <= 3'h0;
      busy_r <= 1'b0;
      hold_r <= 1'b0;
      viol_r <= 1'b0;
      go_r <= 1'b0;
      ref_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      wait_r <= wait_nxt;
      en_r <= en_nxt;
      div_r <= div_nxt;
      block_write_guard_r <= guard_nxt;
      lock_r <= lock_nxt;
      wcnt_r <= wcnt_nxt;
      busy_r <= busy_nxt;
      hold_r <= hold_nxt;
      viol_r <= viol_nxt;
      go_r <= go_nxt;
      ref_r <= ref_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Programming tick generator, valid for every documented clock band
  fap_clk_div u_div (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .div_in(div_r),
    .tick_out(prog_tick_out)
  );

  assign rdata_out = rdata_r;
  assign wait_req_out = rd_take || busy_r;
  assign window_en_out = en_r;
  assign op_go_out = go_r;
  assign op_refused_out = ref_r;
  assign write_violation_flag_out = viol_r;

  a_div_locked: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    bus_in.io_wr && bus_in.addr == FAP_DIV_ADDR && !unlocked |=> $stable(div_r))
    else $error("divider changed while locked");
  a_guard_force: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    bus_in.io_wr && bus_in.addr == FAP_GUARD_ADDR && !unlocked
    |=> block_write_guard_r == FAP_GUARD_ALL)
    else $error("locked guard write did not force all ones");
  a_unlock_seq: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !unlocked ##1 unlocked |-> $past(bus_in.io_wr) && $past(bus_in.wdata) == FAP_KEY_SECOND
    && $past(bus_in.addr) == FAP_KEY_ADDR && $past(lock_r) == FAP_HALF)
    else $error("unlock without key sequence");
  a_relock_both: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    bus_in.io_wr && (bus_in.addr == FAP_DIV_ADDR || bus_in.addr == FAP_GUARD_ADDR)
    |=> lock_r == FAP_LOCKED)
    else $error("register write did not relock");
  a_mass_refuse: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    op_in.mass_erase && (|block_write_guard_r) |=> ref_r && !go_r)
    else $error("mass erase not refused");
  a_wr_violation: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    op_in.wr && block_write_guard_r[blk_idx] |=> viol_r && !go_r)
    else $error("guarded write not refused");
  a_wait_four: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    flash_rd_in && !busy_r && !hold_r && en_r && wait_r == 3'h4 && !bus_in.io_wr
    |-> wait_req_out [*5] ##1 !wait_req_out)
    else $error("wait request length wrong for four waits");
  a_ctrl_write: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    bus_in.io_wr && bus_in.addr == FAP_CTRL_ADDR
    |=> wait_r == $past(bus_in.wdata[7:5]) && en_r == $past(bus_in.wdata[3]))
    else $error("access control write not stored");
endmodule : fap_top

// file: verif/fap_core_model.sv
/*
  Processor core model: I/O bus cycles, flash reads, flash requests.
  Assumes the bench calls its tasks from the falling clock edge.
*/
module fap_core_model
  import fap_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Toward the block
  output fap_bus_s bus_out,
  output logic flash_rd_out,
  output fap_op_s op_out,
  output logic clr_out,
  // From the block
  input wire logic wait_req_in,
  input wire logic go_in,
  input wire logic refused_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Software settings: 5 waits give the 6 cycles of 60 ns at 100 MHz
  localparam logic [2:0] SAFE_WAIT = 3'(FAP_ACCESS_CYC - 1);
  localparam logic [7:0] DIV_20MHZ = 8'h66;
  localparam logic [7:0] DIV_LOW_BAND = 8'h03;

  // Idle bus at time zero
  initial begin
    bus_out = '0;
    flash_rd_out = 1'b0;
    op_out = '0;
    clr_out = 1'b0;
  end

  // One bus cycle; released data lines then show the inverse
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    bus_out = '{w, r, 1'b0, a, d};
    @(negedge clk_in);
    bus_out = '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask : cyc

  // One memory access cycle, which breaks a key sequence
  task automatic macc();
    @(negedge clk_in);
    bus_out.mem_acc = 1'b1;
    @(negedge clk_in);
    bus_out.mem_acc = 1'b0;
  endtask : macc

  // Two consecutive key writes
  task automatic unlock();
    cyc(1'b1, 1'b0, FAP_KEY_ADDR, FAP_KEY_FIRST);
    cyc(1'b1, 1'b0, FAP_KEY_ADDR, FAP_KEY_SECOND);
  endtask : unlock

  // Flash read held until the stall drops; returns extra cycles
  task automatic fread(output int n);
    @(negedge clk_in);
    flash_rd_out = 1'b1;
    #1;
    n = 0;
    while (wait_req_in === 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    flash_rd_out = 1'b0;
    n = (n > 0) ? n - 1 : 0;
  endtask : fread

  // One request pulse; answer caught over the next two cycles
  task automatic op(input fap_op_s o, output logic go, output logic rf);
    @(negedge clk_in);
    op_out = o;
    @(negedge clk_in);
    op_out = '0;
    go = go_in;
    rf = refused_in;
    @(negedge clk_in);
    go = go | go_in;
    rf = rf | refused_in;
  endtask : op

  // Flag clear pulse
  task automatic clear();
    @(negedge clk_in);
    clr_out = 1'b1;
    @(negedge clk_in);
    clr_out = 1'b0;
  endtask : clear
endmodule : fap_core_model

// file: verif/tb.sv
/*
  Self-checking bench for the flash access and protection block.
  Assumes the core model drives all block inputs except clock and reset at falling edges.
*/
module tb
  import fap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  fap_bus_s bus;
  fap_op_s op;
  logic [7:0] rdata;
  logic flash_rd, wait_req, win_en, go, refused, vflag, vclr, tick;
  int fails = 0;
  int n_tests = 0;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // Block and core
  fap_top i_fap_top (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .bus_in(bus),
    .rdata_out(rdata), .flash_rd_in(flash_rd), .wait_req_out(wait_req),
    .window_en_out(win_en), .op_in(op), .op_go_out(go), .op_refused_out(refused),
    .write_violation_flag_out(vflag), .violation_clr_in(vclr), .prog_tick_out(tick));
  fap_core_model i_fap_core_model (.clk_in(sys_clk), .bus_out(bus), .flash_rd_out(flash_rd),
    .op_out(op), .clr_out(vclr), .wait_req_in(wait_req), .go_in(go), .refused_in(refused));

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_fap_core_model.cyc(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_fap_core_model.cyc(1'b0, 1'b1, a, 8'h00);
    check(rdata, e);
  endtask : rd

  task automatic fr(input logic [7:0] e);
    int n;
    i_fap_core_model.fread(n);
    check(n[7:0], e);
  endtask : fr

  task automatic opc(input fap_op_s o, input logic [1:0] e);
    logic g;
    logic r;
    i_fap_core_model.op(o, g, r);
    check({6'h00, g, r}, {6'h00, e});
  endtask : opc

  // Reset values and default stall
  task automatic t_reset();
    rd(FAP_CTRL_ADDR, 8'h88);
    rd(FAP_DIV_ADDR, 8'h01);
    rd(FAP_GUARD_ADDR, 8'hff);
    fr(8'h04);
  endtask : t_reset

  // Every wait count, reserved bits, window off
  task automatic t_wait();
    for (int w = 0; w < 8; w++) begin
      wr(FAP_CTRL_ADDR, {w[2:0], 5'h08});
      rd(FAP_CTRL_ADDR, {w[2:0], 5'h08});
      fr({5'h00, w[2:0]});
    end
    wr(FAP_CTRL_ADDR, 8'hff);
    rd(FAP_CTRL_ADDR, 8'he8);
    wr(FAP_CTRL_ADDR, {i_fap_core_model.SAFE_WAIT, 5'h00});
    fr(8'h00);
    check({7'h00, win_en}, 8'h00);
    i_fap_core_model.unlock();
    wr(FAP_DIV_ADDR, i_fap_core_model.DIV_20MHZ);
    rd(FAP_DIV_ADDR, i_fap_core_model.DIV_20MHZ);
    wr(FAP_CTRL_ADDR, {i_fap_core_model.SAFE_WAIT, 5'h08});
    fr(8'h05);
  endtask : t_wait

  // Lock, unlock, relock
  task automatic t_lock();
    wr(FAP_DIV_ADDR, 8'h20);
    rd(FAP_DIV_ADDR, 8'h66);
    i_fap_core_model.unlock();
    wr(FAP_DIV_ADDR, 8'h0a);
    rd(FAP_DIV_ADDR, 8'h0a);
    wr(FAP_DIV_ADDR, 8'h20);
    rd(FAP_DIV_ADDR, 8'h0a);
    i_fap_core_model.cyc(1'b1, 1'b0, FAP_KEY_ADDR, FAP_KEY_FIRST);
    rd(FAP_CTRL_ADDR, 8'ha8);
    i_fap_core_model.cyc(1'b1, 1'b0, FAP_KEY_ADDR, FAP_KEY_SECOND);
    wr(FAP_DIV_ADDR, 8'h20);
    rd(FAP_DIV_ADDR, 8'h0a);
    i_fap_core_model.unlock();
    wr(FAP_GUARD_ADDR, 8'h5a);
    rd(FAP_GUARD_ADDR, 8'h5a);
    wr(FAP_DIV_ADDR, 8'h20);
    rd(FAP_DIV_ADDR, 8'h0a);
    wr(FAP_GUARD_ADDR, 8'h00);
    rd(FAP_GUARD_ADDR, 8'hff);
    i_fap_core_model.cyc(1'b1, 1'b0, FAP_KEY_ADDR, FAP_KEY_FIRST);
    i_fap_core_model.macc();
    i_fap_core_model.cyc(1'b1, 1'b0, FAP_KEY_ADDR, FAP_KEY_SECOND);
    wr(FAP_DIV_ADDR, 8'h20);
    rd(FAP_DIV_ADDR, 8'h0a);
    i_fap_core_model.unlock();
    wr(FAP_DIV_ADDR, 8'hff);
    rd(FAP_DIV_ADDR, 8'hff);
    i_fap_core_model.unlock();
    wr(FAP_DIV_ADDR, 8'h00);
    rd(FAP_DIV_ADDR, 8'hff);
  endtask : t_lock

  // Guard per block, its bounds, mass erase, violation flag
  task automatic t_ops();
    logic [FAP_OFS_W-1:0] base;
    for (int b = 0; b < 8; b++) begin
      base = FAP_OFS_W'(b << FAP_BLK_LSB);
      i_fap_core_model.unlock();
      wr(FAP_GUARD_ADDR, 8'(8'h01 << b));
      opc('{1'b1, 1'b0, 1'b0, base}, 2'b01);
      check({7'h00, vflag}, 8'h01);
      opc('{1'b0, 1'b1, 1'b0, base + 17'h03fff}, 2'b01);
      opc('{1'b1, 1'b0, 1'b0, base ^ 17'h04000}, 2'b10);
      opc('{1'b0, 1'b0, 1'b1, 17'h00000}, 2'b01);
      i_fap_core_model.clear();
      check({7'h00, vflag}, 8'h00);
    end
    i_fap_core_model.unlock();
    wr(FAP_GUARD_ADDR, 8'h00);
    opc('{1'b0, 1'b0, 1'b1, 17'h00000}, 2'b10);
    wr(FAP_CTRL_ADDR, 8'h00);
    opc('{1'b1, 1'b0, 1'b0, 17'h1ffff}, 2'b10);
  endtask : t_ops

  // Tick count over 30 cycles for two dividers
  task automatic t_tick(input logic [7:0] d);
    int n;
    i_fap_core_model.unlock();
    wr(FAP_DIV_ADDR, d);
    repeat (16) @(negedge sys_clk);
    n = 0;
    for (int i = 0; i < 30; i++) begin
      @(negedge sys_clk);
      n += int'(tick === 1'b1);
    end
    check(n[7:0], 8'(30 / d));
  endtask : t_tick

  // Verdict and end of run
  task automatic finish_test();
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_wait();
    t_lock();
    t_ops();
    t_tick(i_fap_core_model.DIV_LOW_BAND);
    t_tick(8'h05);
    finish_test();
  end

  // Watchdog
  initial begin
    #300us;
    fails++;
    finish_test();
  end
endmodule : tb
